// ### rtl/serial_comm_if.sv
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Contract
// - async characters framed individually, start plus stop
// - independent transmit and receive run together
// - holding register plus shifter on both sides
// - idle line rests high
// - frame starts with low start bit
// - data bits follow, lsb first
// - parity or multiprocessor bit, then stops
// - receiver samples on 8th of 16
// - synchronous mode: eight data bits only
// - synchronous receive flags only overrun
// - sync internal clock driven out
// - sync external clock taken from pin
// - mode bits select format
// - async internal, clock pin unused
// - async clock output at bit rate
// - async external clock at 16x
// - sync ignores clock output enable
// - multiprocessor needs global enable too
// - received parity checked, even or odd
module serial_comm_if (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rstn,
  input  wire logic [serial_pkg::AW-1:0] i_addr,
  input  wire logic [serial_pkg::DW-1:0] i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [serial_pkg::DW-1:0] o_rdata,
  input  wire logic                    i_rxd,
  output logic                         o_txd,
  input  wire logic                    i_sck,
  output logic                         o_sck,
  output logic                         o_sck_oe,
  output logic                         o_irq
);
  import serial_pkg::*;

  // ===========================================================================
  // registers
  logic [7:0]        serial_mode_ff;
  logic [7:0]        serial_ctrl_ff;
  logic [7:0]        baud_div_ff;
  logic [7:0]        serial_timer_ctrl_ff;
  logic [IRQ_W-1:0]  irq_mask_ff;
  logic [IRQ_W-1:0]  irq_status_ff;
  logic [IRQ_W-1:0]  irq_set;
  logic              wr_mode, wr_ctrl, wr_baud, wr_tx, wr_irq, wr_mask, wr_tc, rd_rx;

  assign wr_mode = i_wr && (i_addr == ADDR_SERIAL_MODE);
  assign wr_ctrl = i_wr && (i_addr == ADDR_SERIAL_CTRL);
  assign wr_baud = i_wr && (i_addr == ADDR_BAUD_DIV);
  assign wr_tx   = i_wr && (i_addr == ADDR_TX_DATA);
  assign wr_irq  = i_wr && (i_addr == ADDR_IRQ_STATUS);
  assign wr_mask = i_wr && (i_addr == ADDR_IRQ_MASK);
  assign wr_tc   = i_wr && (i_addr == ADDR_TIMER_CTRL);
  assign rd_rx   = i_rd && (i_addr == ADDR_RX_DATA);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      serial_mode_ff       <= SERIAL_MODE_RST;
      serial_ctrl_ff       <= SERIAL_CTRL_RST;
      baud_div_ff          <= BAUD_DIV_RST;
      serial_timer_ctrl_ff <= TIMER_CTRL_RST;
      irq_mask_ff          <= IRQ_MASK_RST;
    end else begin
      if (wr_mode) serial_mode_ff <= i_wdata;
      if (wr_ctrl) serial_ctrl_ff <= i_wdata;
      if (wr_baud) baud_div_ff <= i_wdata;
      if (wr_tc)   serial_timer_ctrl_ff <= i_wdata;
      if (wr_mask) irq_mask_ff <= i_wdata[IRQ_W-1:0];
    end
  end

  // format decode
  logic sync_m, char7, par_en, par_odd, stop2, ext_clk, clk_out, tx_en, rx_en;
  logic multiproc_on;
  logic [7:0] data_mask;
  assign sync_m   = serial_mode_ff[MODE_SYNC];
  assign char7    = serial_mode_ff[MODE_CHAR7];
  assign par_en   = serial_mode_ff[MODE_PAR_EN];
  assign par_odd  = serial_mode_ff[MODE_PAR_ODD];
  assign stop2    = serial_mode_ff[MODE_STOP2];
  assign ext_clk  = serial_ctrl_ff[CTRL_EXT_CLK];
  assign clk_out  = serial_ctrl_ff[CTRL_CLK_OUT];
  assign tx_en    = serial_ctrl_ff[CTRL_TX_EN];
  assign rx_en    = serial_ctrl_ff[CTRL_RX_EN];
  // multiprocessor bit replaces parity only with both enables set
  assign multiproc_on = serial_mode_ff[MODE_MULTIPROC]
                        && serial_timer_ctrl_ff[TC_MULTIPROC_EN];
  assign data_mask = char7 ? 8'h7f : 8'hff;

  // ===========================================================================
  // clock sources
  logic [7:0] baud_cnt_ff;
  logic       baud_tick, sck_q_ff, ext_rise, ext_fall, tick16, sync_run;
  logic [3:0] clk_ph_ff;
  logic       sck_int_ff, sck_rise_s, sck_fall_s;
  tx_state_t  tx_st_ff;
  rx_state_t  rx_st_ff;
  logic       rx_full_ff;

  assign baud_tick = (baud_cnt_ff == baud_div_ff);
  assign ext_rise  = i_sck && !sck_q_ff;
  assign ext_fall  = !i_sck && sck_q_ff;
  // async: 16x tick from generator or, bypassing it, from pin
  assign tick16    = ext_clk ? ext_rise : baud_tick;
  assign sync_run  = (tx_st_ff == TX_SHIFT) || ((rx_st_ff == RX_BITS) && !rx_full_ff);
  assign sck_rise_s = ext_clk ? ext_rise : (baud_tick && !sck_int_ff && sync_run);
  assign sck_fall_s = ext_clk ? ext_fall : (baud_tick && sck_int_ff && sync_run);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || baud_tick) baud_cnt_ff <= 8'h00;
    else baud_cnt_ff <= baud_cnt_ff + 8'h01;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) sck_q_ff <= 1'b1;
    else sck_q_ff <= i_sck;
  end

  // free 16x phase: bit boundaries at wrap, output clock rises mid bit
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || sync_m) clk_ph_ff <= 4'h0;
    else if (tick16) clk_ph_ff <= clk_ph_ff + 4'h1;
  end

  // sync internal clock idles high and toggles only while shifting
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !sync_m || !sync_run) sck_int_ff <= 1'b1;
    else if (baud_tick && !ext_clk) sck_int_ff <= !sck_int_ff;
  end

  // clock pin function
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_sck    <= 1'b1;
      o_sck_oe <= 1'b0;
    end else if (sync_m) begin
      o_sck    <= sck_int_ff;
      o_sck_oe <= !ext_clk;
    end else begin
      o_sck    <= clk_ph_ff[3];
      o_sck_oe <= !ext_clk && clk_out;
    end
  end

  // ===========================================================================
  // transmitter
  logic [7:0]         tx_hold_ff;
  logic               tx_full_ff;
  logic [FRAME_W-1:0] tx_sh_ff, tx_frame;
  logic [3:0]         tx_left_ff, tx_len;
  logic               tx_bit, tx_load, tx_last, tx_par;

  assign tx_bit  = sync_m ? sck_fall_s : (tick16 && (clk_ph_ff == LAST_PHASE));
  assign tx_last = (tx_st_ff == TX_SHIFT) && tx_bit && (tx_left_ff == 4'h1);
  // next character loads at the last bit edge, so there is no gap
  assign tx_load = tx_en && tx_full_ff
                   && (((tx_st_ff == TX_IDLE) && (sync_m || tx_bit)) || tx_last);
  assign tx_par  = ^(tx_hold_ff & data_mask) ^ par_odd;

  always_comb begin : frame_build
    int n;
    int k;
    n = 0;
    k = 0;
    tx_frame = '1;
    tx_len = SYNC_TX_LEN;
    if (sync_m) begin
      tx_frame = {3'b111, tx_hold_ff, 1'b1};
    end else begin
      n = char7 ? 7 : 8;
      tx_frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < n) tx_frame[i+1] = tx_hold_ff[i];
      end
      k = n + 1;
      if (multiproc_on) begin
        tx_frame[k] = serial_ctrl_ff[CTRL_MPB_TX];
        k = k + 1;
      end else if (par_en) begin
        tx_frame[k] = tx_par;
        k = k + 1;
      end
      k = k + (stop2 ? 2 : 1);
      tx_len = 4'(k);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      tx_hold_ff <= 8'h00;
      tx_full_ff <= 1'b0;
    end else begin
      if (wr_tx) tx_hold_ff <= i_wdata;
      if (wr_tx) tx_full_ff <= 1'b1;
      else if (tx_load) tx_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !tx_en) begin
      tx_st_ff   <= TX_IDLE;
      tx_sh_ff   <= '1;
      tx_left_ff <= 4'h0;
    end else if (tx_load && sync_m && (tx_st_ff == TX_SHIFT)) begin
      tx_sh_ff   <= {1'b1, tx_frame[FRAME_W-1:1]};
      tx_left_ff <= tx_len - 4'h1;
    end else if (tx_load) begin
      tx_st_ff   <= TX_SHIFT;
      tx_sh_ff   <= tx_frame;
      tx_left_ff <= tx_len;
    end else if (tx_last) begin
      tx_st_ff   <= TX_IDLE;
    end else if ((tx_st_ff == TX_SHIFT) && tx_bit) begin
      tx_sh_ff   <= {1'b1, tx_sh_ff[FRAME_W-1:1]};
      tx_left_ff <= tx_left_ff - 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) o_txd <= 1'b1;
    else o_txd <= (tx_st_ff == TX_SHIFT) ? tx_sh_ff[0] : 1'b1;
  end

  // ===========================================================================
  // receiver
  logic               rxd_q_ff, rx_smp, rx_done, rx_mpb_ff;
  logic [3:0]         rx_ph_ff, rx_cnt_ff, rx_need;
  logic [FRAME_W-1:0] rx_sh_ff, rx_word;
  logic [7:0]         rx_data, rx_data_ff;
  logic               rx_stop, rx_extra, rx_fer, rx_per;

  assign rx_smp  = sync_m ? sck_rise_s : (tick16 && (rx_ph_ff == SAMPLE_PHASE));
  assign rx_need = sync_m ? SYNC_RX_LEN
                   : 4'(tx_len - (stop2 ? 4'h1 : 4'h0)); // only first stop is checked
  assign rx_done = (rx_st_ff == RX_BITS) && rx_smp && (4'(rx_cnt_ff + 4'h1) == rx_need);

  always_comb begin : rx_unpack
    int n;
    n = char7 ? 7 : 8;
    rx_word  = {i_rxd, rx_sh_ff[FRAME_W-1:1]} >> (4'hc - rx_need);
    rx_data  = sync_m ? rx_word[7:0] : (rx_word[8:1] & data_mask);
    rx_extra = rx_word[n+1];
    rx_stop  = rx_word[rx_need-4'h1];
    rx_fer   = !sync_m && !rx_stop;
    rx_per   = !sync_m && par_en && !multiproc_on
               && ((^rx_data ^ par_odd) != rx_extra);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) rxd_q_ff <= 1'b1;
    else rxd_q_ff <= i_rxd;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !rx_en) begin
      rx_st_ff  <= RX_IDLE;
      rx_ph_ff  <= 4'h0;
      rx_cnt_ff <= 4'h0;
      rx_sh_ff  <= '1;
    end else begin
      if (tick16) rx_ph_ff <= rx_ph_ff + 4'h1;
      case (rx_st_ff)
        RX_IDLE: begin
          if (sync_m) begin
            rx_st_ff  <= RX_BITS;
            rx_cnt_ff <= 4'h0;
          end else if (rxd_q_ff && !i_rxd) begin
            rx_st_ff <= RX_START;
            rx_ph_ff <= 4'h0;
          end
        end
        RX_START: begin
          if (rx_smp && i_rxd) rx_st_ff <= RX_IDLE;     // glitch, not a start bit
          else if (rx_smp) begin
            rx_st_ff  <= RX_BITS;
            rx_cnt_ff <= 4'h1;
            rx_sh_ff  <= {i_rxd, rx_sh_ff[FRAME_W-1:1]};
          end
        end
        RX_BITS: begin
          if (rx_done) begin
            rx_st_ff  <= sync_m ? RX_BITS : RX_IDLE;
            rx_cnt_ff <= 4'h0;
          end else if (rx_smp) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            rx_sh_ff  <= {i_rxd, rx_sh_ff[FRAME_W-1:1]};
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  logic rx_ovr, rx_good;
  assign rx_ovr  = rx_done && rx_full_ff && !rd_rx;
  assign rx_good = rx_done && !rx_ovr && !rx_fer && !rx_per;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rx_data_ff <= 8'h00;
      rx_full_ff <= 1'b0;
      rx_mpb_ff  <= 1'b0;
    end else begin
      if (rx_good) begin
        rx_data_ff <= rx_data;
        rx_mpb_ff  <= multiproc_on && rx_extra;
      end
      if (rx_good) rx_full_ff <= 1'b1;
      else if (rd_rx) rx_full_ff <= 1'b0;
    end
  end

  // ===========================================================================
  // interrupts: sticky events, write one to clear, set wins
  assign irq_set[IRQ_RX_FULL]  = rx_good;
  assign irq_set[IRQ_TX_EMPTY] = tx_load;
  assign irq_set[IRQ_TX_END]   = tx_last && !tx_load;
  assign irq_set[IRQ_OVERRUN]  = rx_ovr;
  assign irq_set[IRQ_FRAMING]  = rx_done && rx_fer;
  assign irq_set[IRQ_PARITY]   = rx_done && rx_per;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) irq_status_ff <= '0;
    else irq_status_ff <= (irq_status_ff & ~(wr_irq ? i_wdata[IRQ_W-1:0] : '0)) | irq_set;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) o_irq <= 1'b0;
    else o_irq <= |(irq_status_ff & irq_mask_ff);
  end

  // ===========================================================================
  // read port
  logic [7:0] status_rd;
  assign status_rd = {4'h0, rx_mpb_ff, rx_full_ff,
                      (tx_st_ff == TX_IDLE) && !tx_full_ff, !tx_full_ff};

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !i_rd) o_rdata <= 8'h00;
    else begin
      case (i_addr)
        ADDR_SERIAL_MODE: o_rdata <= serial_mode_ff;
        ADDR_SERIAL_CTRL: o_rdata <= serial_ctrl_ff;
        ADDR_BAUD_DIV:    o_rdata <= baud_div_ff;
        ADDR_TX_DATA:     o_rdata <= tx_hold_ff;
        ADDR_RX_DATA:     o_rdata <= rx_data_ff;
        ADDR_STATUS:      o_rdata <= status_rd;
        ADDR_IRQ_STATUS:  o_rdata <= {2'b00, irq_status_ff};
        ADDR_IRQ_MASK:    o_rdata <= {2'b00, irq_mask_ff};
        ADDR_TIMER_CTRL:  o_rdata <= serial_timer_ctrl_ff;
        default:          o_rdata <= 8'h00;
      endcase
    end
  end

  // ===========================================================================
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_async_load;
    !sync_m && (tx_st_ff == TX_IDLE) && tx_load;
  endsequence
  sequence s_start_out;
    ##2 !o_txd;
  endsequence

  a_idle_mark: assert property ($past(tx_st_ff == TX_IDLE) |-> o_txd)
    else $error("line not at mark while idle");
  a_start_low: assert property (s_async_load |-> s_start_out)
    else $error("frame did not open with low start bit");
  a_frame_len: assert property (s_async_load |=> tx_left_ff == $past(tx_len))
    else $error("frame length not taken from format");
  a_rx_centre: assert property ((rx_st_ff == RX_START) && rx_smp |-> rx_ph_ff == 4'h7)
    else $error("receiver sampled away from bit centre");
  a_sync_errs: assert property (sync_m && rx_done |-> !rx_fer && !rx_per)
    else $error("sync receive flagged a non-overrun error");
  a_ovr_flag: assert property (rx_done && rx_full_ff && !rd_rx |=> irq_status_ff[IRQ_OVERRUN])
    else $error("overrun not flagged");
  a_pin_async: assert property (!sync_m && !ext_clk && !clk_out |=> !o_sck_oe)
    else $error("clock pin driven while unused");
  a_pin_sync: assert property (sync_m && !ext_clk |=> o_sck_oe)
    else $error("sync internal clock not driven");
  a_pin_ext: assert property (ext_clk |=> !o_sck_oe)
    else $error("clock pin driven while external");
  a_mp_gate: assert property (!serial_timer_ctrl_ff[TC_MULTIPROC_EN] |-> !multiproc_on)
    else $error("multiprocessor format without global enable");
  a_sync_len: assert property (sync_m && (tx_st_ff == TX_IDLE) && tx_load
                               |=> tx_left_ff == 4'h9)
    else $error("sync frame not eight data bits");
endmodule : serial_comm_if

// ### rtl/serial_pkg.sv
package serial_pkg;
  // ===========================================================================
  // bus and register map
  localparam int unsigned AW                = 4;
  localparam int unsigned DW                = 8;
  localparam logic [3:0]  ADDR_SERIAL_MODE  = 4'h0;
  localparam logic [3:0]  ADDR_SERIAL_CTRL  = 4'h1;
  localparam logic [3:0]  ADDR_BAUD_DIV     = 4'h2;
  localparam logic [3:0]  ADDR_TX_DATA      = 4'h3;
  localparam logic [3:0]  ADDR_RX_DATA      = 4'h4;
  localparam logic [3:0]  ADDR_STATUS       = 4'h5;
  localparam logic [3:0]  ADDR_IRQ_STATUS   = 4'h6;
  localparam logic [3:0]  ADDR_IRQ_MASK     = 4'h7;
  localparam logic [3:0]  ADDR_TIMER_CTRL   = 4'h8;
  // ===========================================================================
  // field positions
  localparam int unsigned MODE_SYNC         = 7;
  localparam int unsigned MODE_CHAR7        = 6;
  localparam int unsigned MODE_PAR_EN       = 5;
  localparam int unsigned MODE_PAR_ODD      = 4;
  localparam int unsigned MODE_STOP2        = 3;
  localparam int unsigned MODE_MULTIPROC    = 2;
  localparam int unsigned CTRL_TX_EN        = 5;
  localparam int unsigned CTRL_RX_EN        = 4;
  localparam int unsigned CTRL_MPB_TX       = 2;
  localparam int unsigned CTRL_EXT_CLK      = 1;
  localparam int unsigned CTRL_CLK_OUT      = 0;
  localparam int unsigned TC_MULTIPROC_EN   = 2;
  localparam int unsigned ST_TX_EMPTY       = 0;
  localparam int unsigned ST_TX_END         = 1;
  localparam int unsigned ST_RX_FULL        = 2;
  localparam int unsigned ST_RX_MPB         = 3;
  localparam int unsigned IRQ_RX_FULL       = 0;
  localparam int unsigned IRQ_TX_EMPTY      = 1;
  localparam int unsigned IRQ_TX_END        = 2;
  localparam int unsigned IRQ_OVERRUN       = 3;
  localparam int unsigned IRQ_FRAMING       = 4;
  localparam int unsigned IRQ_PARITY        = 5;
  localparam int unsigned IRQ_W             = 6;
  // ===========================================================================
  // reset values and timing counts
  localparam logic [7:0]  SERIAL_MODE_RST   = 8'h00;
  localparam logic [7:0]  SERIAL_CTRL_RST   = 8'h00;
  localparam logic [7:0]  BAUD_DIV_RST      = 8'h00;
  localparam logic [7:0]  TIMER_CTRL_RST    = 8'h00;
  localparam logic [5:0]  IRQ_MASK_RST      = 6'h00;
  localparam logic [3:0]  SAMPLE_PHASE      = 4'h7;
  localparam logic [3:0]  LAST_PHASE        = 4'hf;
  localparam int unsigned FRAME_W           = 12;
  localparam logic [3:0]  SYNC_TX_LEN       = 4'h9;
  localparam logic [3:0]  SYNC_RX_LEN       = 4'h8;
  // ===========================================================================
  // states
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
endpackage : serial_pkg

// ### dv/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
  input  wire logic i_clk,
  input  wire logic i_txd,
  input  wire logic i_sck,
  output logic      o_rxd,
  output logic      o_sck
);
  int bit_clks = 32;
  int sck_half = 0;
  int sck_cnt  = 0;

  initial begin
    o_rxd = 1'b1;
    o_sck = 1'b1;
  end

  // ==========
  // external clock, runs only while a half period is set
  always @(posedge i_clk) begin
    sck_cnt = sck_cnt + 1;
    if (sck_half == 0) begin
      o_sck <= 1'b1;
    end else if (sck_cnt >= sck_half) begin
      o_sck <= ~o_sck;
      sck_cnt = 0;
    end
  end

  // ==========
  // async frame out, bit 0 first
  task send(input logic [11:0] fr, input int n);
    for (int i = 0; i < n; i++) begin
      o_rxd <= fr[i];
      repeat (bit_clks) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
  endtask : send

  // ==========
  // async frame in, sampled mid-bit
  task recv(output logic [11:0] fr, input int n);
    int w;
    fr = '1;
    w = 0;
    while (i_txd !== 1'b0 && w < 4000) begin
      @(posedge i_clk);
      w++;
    end
    repeat (bit_clks / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      fr[i] = i_txd;
      repeat (bit_clks) @(posedge i_clk);
    end
  endtask : recv

  // ==========
  // clocked byte in, taken on rising clock
  task sync_recv(output logic [7:0] b);
    int k;
    int w;
    logic p;
    k = 0;
    w = 0;
    p = i_sck;
    b = '0;
    while (k < 8 && w < 4000) begin
      @(posedge i_clk);
      #1;
      w++;
      if (i_sck === 1'b1 && p === 1'b0) begin
        b[k] = i_txd;
        k++;
      end
      p = i_sck;
    end
  endtask : sync_recv
endmodule : serial_peer

// ### dv/serial_format_clock_select_bench.sv
`timescale 1ns/1ps
module serial_format_clock_select_bench;
  import serial_pkg::*;
  logic          i_ref_clk = 1'b0;
  logic          i_rstn    = 1'b0;
  logic [AW-1:0] i_addr    = '0;
  logic [DW-1:0] i_wdata   = '0;
  logic          i_wr      = 1'b0;
  logic          i_rd      = 1'b0;
  logic [DW-1:0] o_rdata;
  logic          o_txd, o_sck, o_sck_oe, o_irq, rxd, peer_sck, sck_pin;
  logic [11:0]   f, g;
  logic [7:0]    d, m, r;
  int            n, c, err_total = 0, n_compared = 0;
  localparam logic [7:0] CM [6] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80};
  localparam logic [7:0] CC [6] = '{8'h00, 8'h01, 8'h03, 8'h00, 8'h01, 8'h02};
  localparam logic       CO [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  always #2 i_ref_clk = ~i_ref_clk;
  // shared clock pin, taken from the peer (idling high) whenever the design does not drive it
  assign sck_pin = o_sck_oe ? o_sck : peer_sck;

  serial_comm_if serial_comm_if_inst (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(rxd), .o_txd(o_txd),
    .i_sck(sck_pin), .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_irq(o_irq));
  serial_peer serial_peer_inst (
    .i_clk(i_ref_clk), .i_txd(o_txd), .i_sck(sck_pin), .o_rxd(rxd), .o_sck(peer_sck));

  // ==========
  // bus and check helpers
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask : rd

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask : cyc

  // period of the clock pin in reference cycles
  task sck_gap(output int cnt);
    int k;
    logic p;
    k = 0;
    cnt = 0;
    p = o_sck;
    while (k < 2 && cnt < 2000) begin
      @(posedge i_ref_clk);
      #1;
      if (k == 1) cnt++;
      if (o_sck === 1'b1 && p === 1'b0) k++;
      p = o_sck;
    end
  endtask : sck_gap

  // expected async frame: start, data, parity, stops
  function automatic int fbits(input logic [7:0] dv, input logic [7:0] mv,
                               output logic [11:0] fv);
    int k;
    fv = '1;
    fv[0] = 1'b0;
    k = 1;
    for (int i = 0; i < (mv[6] ? 7 : 8); i++) begin
      fv[k] = dv[i];
      k++;
    end
    if (mv[5]) begin
      fv[k] = (mv[6] ? ^dv[6:0] : ^dv) ^ mv[4];
      k++;
    end
    return k + (mv[3] ? 2 : 1);
  endfunction : fbits

  task test_done();
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    cyc(40000);
    err_total++;
    test_done();
  end

  // ==========
  // main sequence
  initial begin
    void'($urandom(26));
    cyc(6);
    i_rstn <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      if (a != 5 && a != 6) begin
        rd(a[3:0], r);
        chk(r, 8'h00);
      end
    end
    m = $urandom & 8'h7c;
    wr(ADDR_SERIAL_MODE, m);
    wr(ADDR_BAUD_DIV, 8'h01);
    rd(ADDR_SERIAL_MODE, r);
    chk(r, m);
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_SERIAL_MODE, CM[k]);
      wr(ADDR_SERIAL_CTRL, CC[k]);
      cyc(3);
      chk(o_sck_oe, CO[k]);
      if (k == 1) begin
        sck_gap(c);
        chk(c[15:0], 16'd32);
      end
    end
    // async transmit, first format fixed at 8'h7c, the rest drawn at random
    for (int k = 0; k < 4; k++) begin
      m = (k == 0) ? 8'h7c : ($urandom & 8'h7c);
      wr(ADDR_SERIAL_CTRL, 8'h00);
      wr(ADDR_SERIAL_MODE, m);
      wr(ADDR_SERIAL_CTRL, 8'h20);
      d = $urandom;
      wr(ADDR_TX_DATA, d);
      n = fbits(d, m, g);
      serial_peer_inst.recv(f, n);
      chk(f, g);
      cyc(48);
      chk(o_txd, 1'b1);
    end
    // clocked transmit on internal clock
    wr(ADDR_SERIAL_CTRL, 8'h00);
    wr(ADDR_BAUD_DIV, 8'h03);
    wr(ADDR_SERIAL_MODE, 8'h80);
    wr(ADDR_SERIAL_CTRL, 8'h21);
    d = $urandom;
    wr(ADDR_TX_DATA, d);
    serial_peer_inst.sync_recv(r);
    chk(r, d);
    // async receive with interrupt, ext clock once, bad parity last
    wr(ADDR_SERIAL_CTRL, 8'h00);
    wr(ADDR_BAUD_DIV, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h3f);
    wr(ADDR_IRQ_MASK, 8'h01);
    for (int k = 0; k < 4; k++) begin
      m = (k == 0) ? 8'h30 : (k == 3) ? 8'h20 : ($urandom & 8'h7c);
      serial_peer_inst.sck_half = (k == 2) ? 2 : 0;
      serial_peer_inst.bit_clks = (k == 2) ? 64 : 32;
      wr(ADDR_SERIAL_MODE, m);
      wr(ADDR_SERIAL_CTRL, (k == 2) ? 8'h12 : 8'h10);
      cyc(64);
      d = $urandom;
      n = fbits(d, m, g);
      if (k == 3) g[9] = ~g[9];
      serial_peer_inst.send(g, n);
      cyc(4);
      chk(o_irq, k != 3);
      rd(ADDR_IRQ_STATUS, r);
      chk(r, (k == 3) ? 8'h20 : 8'h01);
      if (k != 3) begin
        rd(ADDR_RX_DATA, r);
        chk(r, m[6] ? {1'b0, d[6:0]} : d);
      end
      wr(ADDR_IRQ_STATUS, 8'h3f);
      cyc(2);
      chk(o_irq, 1'b0);
      wr(ADDR_SERIAL_CTRL, 8'h00);
    end
    // two frames with no read between: first kept, second overruns
    wr(ADDR_SERIAL_MODE, 8'h00);
    wr(ADDR_SERIAL_CTRL, 8'h10);
    cyc(64);
    d = $urandom;
    n = fbits(d, 8'h00, g);
    serial_peer_inst.send(g, n);
    cyc(2);
    n = fbits(~d, 8'h00, g);
    serial_peer_inst.send(g, n);
    cyc(4);
    rd(ADDR_IRQ_STATUS, r);
    chk(r, 8'h09);
    rd(ADDR_RX_DATA, r);
    chk(r, d);
    test_done();
  end
endmodule : serial_format_clock_select_bench
